// [rtl/demo_regs_pkg.sv]
// constants, field layouts and carrier types for the demo control register bank
// Summary of operation
// - read-only 12-bit posted-data credit, captured by hardware, zero until captured
// - filter control bit 0 turns filter on (reset off), bit 1 inverts (reset on)
// - filter min threshold bits 23-16 reset 100, max bits 31-24 reset 200
// - offload bit 0 routes filtering to processor when set, fabric when clear
// - output route bit 0 sends frames to host when set, local display when clear
// - generator enable bit 0 starts card-to-host channel one traffic, reset zero
// - 16-bit packet length resets to 4096, generator handles up to 32 kilobytes
// - checker bit 0 enables checking, bit 1 enables loopback, both reset zero
// - checker mismatch sets sticky error bit 0, cleared by writing one
// - 32-bit wrap count resets to 511, sets sequence rollover value
// - host registers read-only to processor, processor registers read-only to host
// - host control bit 0 holds host soft reset while set, reset zero
// - host status holds ready, test-started and test-error in bits 0 to 2
// - processor control bit 0 holds processor soft reset while set, reset zero
// - processor status holds ready bit 0 and generator error bit 1
// - reserved bits and unmapped addresses read as zero
// - every register is 32 bits and returns its default after reset
// - host reaches every register at the listed offsets of its memory window
package demo_regs_pkg;
    // register byte offsets inside the host window
    localparam logic [15:0] OFS_FILTER_CTRL   = 16'h0100;
    localparam logic [15:0] OFS_OFFLOAD       = 16'h0104;
    localparam logic [15:0] OFS_OUT_ROUTE     = 16'h0108;
    localparam logic [15:0] OFS_HOST_CTRL     = 16'h0300;
    localparam logic [15:0] OFS_HOST_STAT     = 16'h0304;
    localparam logic [15:0] OFS_PROC_CTRL     = 16'h0400;
    localparam logic [15:0] OFS_PROC_STAT     = 16'h0404;
    localparam logic [15:0] OFS_CREDIT_PD     = 16'h902C;
    localparam logic [15:0] OFS_GEN_EN        = 16'h9200;
    localparam logic [15:0] OFS_PKT_LEN       = 16'h9204;
    localparam logic [15:0] OFS_CHK_LOOP      = 16'h9208;
    localparam logic [15:0] OFS_CHK_ERR       = 16'h920C;
    localparam logic [15:0] OFS_WRAP          = 16'h9210;
    // processor physical base and bias; offset sits in the low 12 bits
    localparam logic [15:0] PROC_BASE_HI      = 16'h4002;
    localparam logic [15:0] PROC_OFS_BIAS     = 16'h9000;
    // field positions and reset values
    localparam int          FLT_MIN_LSB       = 16;
    localparam int          FLT_MAX_LSB       = 24;
    localparam logic [7:0]  FLT_MIN_RST       = 8'h64;
    localparam logic [7:0]  FLT_MAX_RST       = 8'hC8;
    localparam logic [15:0] PKT_LEN_RST       = 16'h1000;
    localparam logic [15:0] PKT_LEN_MAX       = 16'h8000;
    localparam logic [15:0] BEAT_BYTES        = 16'h0004;
    localparam logic [31:0] WRAP_RST          = 32'h0000_01FF;

    // one register access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    // read answer, one cycle after the request
    typedef struct packed {
        logic        rvalid;
        logic [31:0] rdata;
    } bus_rsp_t;

    // video path controls
    typedef struct packed {
        logic [7:0] max_thr;
        logic [7:0] min_thr;
        logic       invert;
        logic       enable;
        logic       to_processor;
        logic       to_host;
    } video_ctrl_t;

    // generator output beat
    typedef struct packed {
        logic        valid;
        logic        last;
        logic [31:0] data;
    } gen_beat_t;
endpackage

// [rtl/demo_control_register_bank.sv]
// host and processor register bank with traffic generator and checker
`timescale 1ns/1ps
module demo_control_register_bank
    import demo_regs_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // host memory window access
    input  wire bus_req_t    host_req_i,
    output bus_rsp_t         host_rsp_o,
    // processor physical access
    input  wire bus_req_t    proc_req_i,
    output bus_rsp_t         proc_rsp_o,
    // initial credit capture from link logic
    input  wire logic        credit_valid_i,
    input  wire logic [11:0] credit_value_i,
    // status flags from processor subsystem and host test logic
    input  wire logic        proc_ready_set_i,
    input  wire logic        gen_dma_err_set_i,
    // generator stream, card to host channel one
    input  wire logic        gen_ready_i,
    output gen_beat_t        gen_beat_o,
    // checker stream, host to card channel one
    input  wire logic        chk_valid_i,
    input  wire logic [31:0] chk_data_i,
    // controls
    output video_ctrl_t      video_ctrl_o,
    output logic             loopback_o,
    output logic             host_soft_reset_o,
    output logic             proc_soft_reset_o
);

    // whole state of the bank
    typedef struct packed {
        logic        credit_taken;
        logic [11:0] credit;
        logic [31:0] filter;
        logic        offload;
        logic        route;
        logic        host_ctrl;
        logic [2:0]  host_stat;
        logic        proc_ctrl;
        logic [1:0]  proc_stat;
        logic        gen_en;
        logic [15:0] pkt_len;
        logic [1:0]  chk_loop;
        logic        chk_err;
        logic [31:0] wrap;
        logic [31:0] gen_seq;
        logic [15:0] gen_bytes;
        logic        gen_last;
        logic [31:0] chk_seq;
        bus_rsp_t    host_rsp;
        bus_rsp_t    proc_rsp;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // read mux shared by both ports; holes and reserved bits give zero
    function automatic logic [31:0] reg_read(input state_t s, input logic [15:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            OFS_FILTER_CTRL: d = {s.filter[31:16], 14'h0000, s.filter[1:0]};
            OFS_OFFLOAD:     d = {31'h0000_0000, s.offload};
            OFS_OUT_ROUTE:   d = {31'h0000_0000, s.route};
            OFS_HOST_CTRL:   d = {31'h0000_0000, s.host_ctrl};
            OFS_HOST_STAT:   d = {29'h0000_0000, s.host_stat};
            OFS_PROC_CTRL:   d = {31'h0000_0000, s.proc_ctrl};
            OFS_PROC_STAT:   d = {30'h0000_0000, s.proc_stat};
            OFS_CREDIT_PD:   d = {20'h0_0000, s.credit};
            OFS_GEN_EN:      d = {31'h0000_0000, s.gen_en};
            OFS_PKT_LEN:     d = {16'h0000, s.pkt_len};
            OFS_CHK_LOOP:    d = {30'h0000_0000, s.chk_loop};
            OFS_CHK_ERR:     d = {31'h0000_0000, s.chk_err};
            OFS_WRAP:        d = s.wrap;
            default:         d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // next value after the wrap count
    function automatic logic [31:0] seq_step(input logic [31:0] q, input logic [31:0] w);
        return (q >= w) ? 32'h0000_0000 : 32'(q + 32'h0000_0001);
    endfunction

    logic [15:0] host_ofs;
    logic [15:0] proc_ofs;
    logic        proc_hit;
    logic        host_wr;
    logic        proc_wr;
    logic [15:0] len_eff;
    logic        gen_fire;

    // address decode for the two ports
    always_comb begin
        host_ofs = host_req_i.addr[15:0];
        proc_hit = (proc_req_i.addr[31:16] == PROC_BASE_HI)
                && (proc_req_i.addr[15:12] == PROC_OFS_BIAS[15:12]);
        proc_ofs = proc_hit ? {4'h0, proc_req_i.addr[11:0]} : 16'hFFFF;
        host_wr  = host_req_i.valid && host_req_i.write;
        proc_wr  = proc_req_i.valid && proc_req_i.write && proc_hit;
        len_eff  = 16'h0000;
        if (st_r.pkt_len == 16'h0000) begin
            len_eff = BEAT_BYTES;
        end else if (st_r.pkt_len > PKT_LEN_MAX) begin
            len_eff = PKT_LEN_MAX;
        end else begin
            len_eff = st_r.pkt_len;
        end
        gen_fire = st_r.gen_en && gen_ready_i;
    end

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        // credit is captured once, on the first valid report
        if (credit_valid_i && !st_r.credit_taken) begin
            st_nxt.credit       = credit_value_i;
            st_nxt.credit_taken = 1'b1;
        end
        // processor writes: its own registers and the shared controls
        if (proc_wr) begin
            unique case (proc_ofs)
                OFS_PROC_CTRL: st_nxt.proc_ctrl = proc_req_i.wdata[0];
                OFS_PROC_STAT: st_nxt.proc_stat = proc_req_i.wdata[1:0];
                OFS_FILTER_CTRL: st_nxt.filter  = proc_req_i.wdata;
                OFS_OFFLOAD:   st_nxt.offload   = proc_req_i.wdata[0];
                OFS_OUT_ROUTE: st_nxt.route     = proc_req_i.wdata[0];
                default: ;
            endcase
        end
        // host writes win over processor writes in the same cycle
        if (host_wr) begin
            unique case (host_ofs)
                OFS_FILTER_CTRL: st_nxt.filter = host_req_i.wdata;
                OFS_OFFLOAD:   st_nxt.offload  = host_req_i.wdata[0];
                OFS_OUT_ROUTE: st_nxt.route    = host_req_i.wdata[0];
                OFS_HOST_CTRL: st_nxt.host_ctrl = host_req_i.wdata[0];
                OFS_HOST_STAT: st_nxt.host_stat = host_req_i.wdata[2:0];
                OFS_GEN_EN:    st_nxt.gen_en   = host_req_i.wdata[0];
                OFS_PKT_LEN:   st_nxt.pkt_len  = host_req_i.wdata[15:0];
                OFS_CHK_LOOP:  st_nxt.chk_loop = host_req_i.wdata[1:0];
                OFS_CHK_ERR: begin
                    if (host_req_i.wdata[0]) begin
                        st_nxt.chk_err = 1'b0;
                    end
                end
                OFS_WRAP:      st_nxt.wrap     = host_req_i.wdata;
                default: ;
            endcase
        end
        // hardware status setters beat software writes
        if (proc_ready_set_i) begin
            st_nxt.proc_stat[0] = 1'b1;
        end
        if (gen_dma_err_set_i) begin
            st_nxt.proc_stat[1] = 1'b1;
        end
        // generator: sequence beats, last flag on packet boundary
        if (!st_r.gen_en) begin
            st_nxt.gen_seq   = 32'h0000_0000;
            st_nxt.gen_bytes = 16'h0000;
            st_nxt.gen_last  = (BEAT_BYTES >= len_eff);
        end else if (gen_fire) begin
            st_nxt.gen_seq = seq_step(st_r.gen_seq, st_r.wrap);
            if (st_r.gen_last) begin
                st_nxt.gen_bytes = 16'h0000;
                st_nxt.gen_last  = (BEAT_BYTES >= len_eff);
            end else begin
                st_nxt.gen_bytes = 16'(st_r.gen_bytes + BEAT_BYTES);
                st_nxt.gen_last  = (st_r.gen_bytes + BEAT_BYTES + BEAT_BYTES >= len_eff);
            end
        end
        // checker: compare against expected sequence, sticky error
        if (!st_r.chk_loop[0]) begin
            st_nxt.chk_seq = 32'h0000_0000;
        end else if (chk_valid_i) begin
            st_nxt.chk_seq = seq_step(st_r.chk_seq, st_r.wrap);
            if (chk_data_i != st_r.chk_seq) begin
                st_nxt.chk_err = 1'b1;
            end
        end
        // registered read answers
        st_nxt.host_rsp.rvalid = host_req_i.valid && !host_req_i.write;
        st_nxt.host_rsp.rdata  = reg_read(st_r, host_ofs);
        st_nxt.proc_rsp.rvalid = proc_req_i.valid && !proc_req_i.write;
        st_nxt.proc_rsp.rdata  = reg_read(st_r, proc_ofs);
    end

    // state register with documented defaults
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r          <= '0;
            st_r.filter   <= {FLT_MAX_RST, FLT_MIN_RST, 14'h0000, 2'h2};
            st_r.pkt_len  <= PKT_LEN_RST;
            st_r.wrap     <= WRAP_RST;
            st_r.gen_last <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign host_rsp_o                = st_r.host_rsp;
    assign proc_rsp_o                = st_r.proc_rsp;
    assign gen_beat_o.valid          = st_r.gen_en;
    assign gen_beat_o.last           = st_r.gen_last;
    assign gen_beat_o.data           = st_r.gen_seq;
    assign video_ctrl_o.enable       = st_r.filter[0];
    assign video_ctrl_o.invert       = st_r.filter[1];
    assign video_ctrl_o.min_thr      = st_r.filter[FLT_MIN_LSB +: 8];
    assign video_ctrl_o.max_thr      = st_r.filter[FLT_MAX_LSB +: 8];
    assign video_ctrl_o.to_processor = st_r.offload;
    assign video_ctrl_o.to_host      = st_r.route;
    assign loopback_o                = st_r.chk_loop[1];
    assign host_soft_reset_o         = st_r.host_ctrl;
    assign proc_soft_reset_o         = st_r.proc_ctrl;

    // checks on the bank
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_host_write(logic [15:0] ofs);
        host_wr && host_ofs == ofs;
    endsequence

    sequence s_host_read(logic [15:0] ofs);
        host_req_i.valid && !host_req_i.write && host_ofs == ofs;
    endsequence

    sequence s_proc_write(logic [15:0] ofs);
        proc_wr && proc_ofs == ofs;
    endsequence

    // a beat offered without ready and still offered one cycle later
    sequence s_beat_stalled;
        gen_beat_o.valid && !gen_ready_i ##1 gen_beat_o.valid;
    endsequence

    AST_CHK_ERR_STICKY: assert property (
        st_r.chk_loop[0] && chk_valid_i && chk_data_i != st_r.chk_seq
        |=> st_r.chk_err)
        else $error("checker mismatch did not set the error flag");

    AST_W1C_CLEAR: assert property (
        s_host_write(OFS_CHK_ERR) ##0 host_req_i.wdata[0]
        ##0 !(st_r.chk_loop[0] && chk_valid_i) |=> !st_r.chk_err)
        else $error("write one did not clear checker error");

    AST_HOST_SOFT_RESET: assert property (
        s_host_write(OFS_HOST_CTRL) |=> host_soft_reset_o == $past(host_req_i.wdata[0]))
        else $error("host soft reset does not follow host control bit");

    AST_PROC_RO_FOR_HOST: assert property (
        s_host_write(OFS_PROC_CTRL) ##0 !proc_wr |=> $stable(proc_soft_reset_o))
        else $error("host write changed processor control");

    AST_HOST_RO_FOR_PROC: assert property (
        proc_wr && proc_ofs == OFS_HOST_CTRL && !host_wr |=> $stable(host_soft_reset_o))
        else $error("processor write changed host control");

    AST_UNMAPPED_ZERO: assert property (
        s_host_read(16'h0010) |=> host_rsp_o.rvalid && host_rsp_o.rdata == 32'h0000_0000)
        else $error("unmapped address did not read zero");

    AST_WRAP_ROLLOVER: assert property (
        gen_fire && st_r.gen_seq >= st_r.wrap |=> gen_beat_o.data == 32'h0000_0000)
        else $error("generator sequence did not wrap at the wrap count");

    AST_GEN_INCREMENT: assert property (
        gen_fire && st_r.gen_seq < st_r.wrap |=> gen_beat_o.data == $past(st_r.gen_seq) + 1)
        else $error("generator sequence did not increment");

    AST_CREDIT_ONCE: assert property (
        st_r.credit_taken |=> $stable(st_r.credit))
        else $error("captured credit changed after capture");

    AST_ROUTE_FOLLOWS: assert property (
        s_host_write(OFS_OUT_ROUTE) |=> video_ctrl_o.to_host == $past(host_req_i.wdata[0]))
        else $error("output routing does not follow register");

    AST_FILTER_BITS: assert property (
        s_host_write(OFS_FILTER_CTRL) |=> video_ctrl_o.enable == $past(host_req_i.wdata[0])
            && video_ctrl_o.invert == $past(host_req_i.wdata[1]))
        else $error("filter enable or invert does not follow register");

    AST_THRESHOLDS: assert property (
        s_host_write(OFS_FILTER_CTRL)
        |=> video_ctrl_o.min_thr == $past(host_req_i.wdata[FLT_MIN_LSB +: 8])
            && video_ctrl_o.max_thr == $past(host_req_i.wdata[FLT_MAX_LSB +: 8]))
        else $error("filter thresholds do not follow register");

    AST_OFFLOAD_FOLLOWS: assert property (
        s_host_write(OFS_OFFLOAD) |=> video_ctrl_o.to_processor == $past(host_req_i.wdata[0]))
        else $error("offload selection does not follow register");

    AST_RESET_DEFAULTS: assert property (
        $fell(reset_i) |-> st_r.pkt_len == PKT_LEN_RST && st_r.wrap == WRAP_RST
            && video_ctrl_o.min_thr == FLT_MIN_RST && video_ctrl_o.max_thr == FLT_MAX_RST
            && video_ctrl_o.invert && !video_ctrl_o.enable && !gen_beat_o.valid)
        else $error("bank did not return to its defaults after reset");

    AST_GEN_ENABLE: assert property (
        s_host_write(OFS_GEN_EN) |=> gen_beat_o.valid == $past(host_req_i.wdata[0]))
        else $error("generator valid does not follow enable bit");

    AST_GEN_OFF_RESTART: assert property (
        !gen_beat_o.valid |=> gen_beat_o.data == 32'h0000_0000)
        else $error("stopped generator did not restart its sequence");

    AST_GEN_HOLD: assert property (
        s_beat_stalled |-> $stable(gen_beat_o.data) && $stable(gen_beat_o.last))
        else $error("generator beat changed while stalled");

    AST_LOOPBACK_FOLLOWS: assert property (
        s_host_write(OFS_CHK_LOOP) |=> loopback_o == $past(host_req_i.wdata[1]))
        else $error("loopback output does not follow register");

    AST_HOST_STATUS: assert property (
        s_host_write(OFS_HOST_STAT) |=> st_r.host_stat == $past(host_req_i.wdata[2:0]))
        else $error("host status does not follow host writes");

    AST_PROC_SOFT_RESET: assert property (
        s_proc_write(OFS_PROC_CTRL) |=> proc_soft_reset_o == $past(proc_req_i.wdata[0]))
        else $error("processor soft reset does not follow its control bit");

    AST_PROC_READY_SET: assert property (
        proc_ready_set_i |=> st_r.proc_stat[0])
        else $error("processor ready request did not set its status bit");

    AST_READ_ANSWER: assert property (
        host_req_i.valid && !host_req_i.write |=> host_rsp_o.rvalid)
        else $error("host read got no answer in the next cycle");

    AST_CHK_ADVANCE: assert property (
        st_r.chk_loop[0] && chk_valid_i && st_r.chk_seq < st_r.wrap
        |=> st_r.chk_seq == $past(st_r.chk_seq) + 32'h0000_0001)
        else $error("checker sequence did not increment");

    AST_CHK_WRAP: assert property (
        st_r.chk_loop[0] && chk_valid_i && st_r.chk_seq >= st_r.wrap
        |=> st_r.chk_seq == 32'h0000_0000)
        else $error("checker sequence did not wrap at the wrap count");

    AST_CREDIT_CAPTURE: assert property (
        credit_valid_i && !st_r.credit_taken |=> st_r.credit == $past(credit_value_i))
        else $error("initial credit was not captured");

endmodule

// [verif/host_proc_model.sv]
// bus master model standing in for the host and the embedded processor
`timescale 1ns/1ps
module host_proc_model
    import demo_regs_pkg::*;
(
    // clock
    input  wire logic     clk_i,
    // requests towards the bank
    output bus_req_t      host_req_o,
    output bus_req_t      proc_req_o,
    // answers from the bank
    input  wire bus_rsp_t host_rsp_i,
    input  wire bus_rsp_t proc_rsp_i
);
    // both masters idle at time zero
    initial begin
        host_req_o = '0;
        proc_req_o = '0;
    end

    // one word access on either port; read data is taken only with rvalid
    task automatic access(input logic proc, input logic wr, input logic [31:0] addr,
                          input logic [31:0] wdata, output logic [31:0] rdata);
        bus_req_t req;
        bus_rsp_t rsp;
        req = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
        @(posedge clk_i);
        if (proc) proc_req_o <= req; else host_req_o <= req;
        @(posedge clk_i);
        // released lines show the inverse so stale values are never trusted
        req = '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
        if (proc) proc_req_o <= req; else host_req_o <= req;
        #1;
        rsp = proc ? proc_rsp_i : host_rsp_i;
        rdata = (rsp.rvalid === 1'b1) ? rsp.rdata : 32'hXXXX_XXXX;
    endtask
endmodule

// [verif/tb_top.sv]
// self-checking testbench for the demo control register bank
`timescale 1ns/1ps
module tb_top;
    import demo_regs_pkg::*;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    bus_req_t    host_req, proc_req;
    bus_rsp_t    host_rsp, proc_rsp;
    logic        credit_valid = 1'b0, proc_ready_set = 1'b0, dma_err_set = 1'b0;
    logic [11:0] credit_value = 12'h000;
    logic        gen_ready = 1'b0, chk_valid = 1'b0;
    logic [31:0] chk_data = 32'h0, rd;
    gen_beat_t   beat;
    video_ctrl_t video;
    logic        loopback, host_srst, proc_srst;
    int          n_fail = 0, total_checks = 0, cycles = 0;
    // host-writable places with their all-ones readback, both processor registers and the read-only credit
    localparam logic [15:0] RW_OFS [12] = '{16'h0100, 16'h0104, 16'h0108, 16'h0300,
        16'h0304, 16'h0400, 16'h0404, 16'h9200, 16'h9204, 16'h9208, 16'h9210, 16'h902C};
    localparam logic [31:0] RW_EXP [12] = '{32'hFFFF_0003, 32'h1, 32'h1, 32'h1, 32'h7,
        32'h0, 32'h0, 32'h1, 32'h0000_FFFF, 32'h3, 32'hFFFF_FFFF, 32'h0};

    demo_control_register_bank demo_control_register_bank_i (
        .clk_i(clk_i), .reset_i(reset_i), .host_req_i(host_req), .host_rsp_o(host_rsp),
        .proc_req_i(proc_req), .proc_rsp_o(proc_rsp), .credit_valid_i(credit_valid),
        .credit_value_i(credit_value), .proc_ready_set_i(proc_ready_set),
        .gen_dma_err_set_i(dma_err_set), .gen_ready_i(gen_ready), .gen_beat_o(beat),
        .chk_valid_i(chk_valid), .chk_data_i(chk_data), .video_ctrl_o(video),
        .loopback_o(loopback), .host_soft_reset_o(host_srst), .proc_soft_reset_o(proc_srst));
    host_proc_model host_proc_model_i (
        .clk_i(clk_i), .host_req_o(host_req), .proc_req_o(proc_req),
        .host_rsp_i(host_rsp), .proc_rsp_i(proc_rsp));

    // 200 MHz clock and hang guard
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // register access on either port, offsets mapped to the port's address space
    task automatic bus(input logic proc, input logic wr, input logic [15:0] ofs,
                       input logic [31:0] d, input logic [31:0] exp);
        logic [31:0] a;
        a = proc ? {PROC_BASE_HI, PROC_OFS_BIAS | ofs} : {16'h0000, ofs};
        host_proc_model_i.access(proc, wr, a, d, rd);
        if (!wr) check(rd, exp);
    endtask
    task automatic hw(input logic [15:0] ofs, input logic [31:0] d);
        bus(1'b0, 1'b1, ofs, d, 32'h0);
    endtask
    task automatic hr(input logic [15:0] ofs, input logic [31:0] exp);
        bus(1'b0, 1'b0, ofs, 32'h0, exp);
    endtask
    task automatic outs(input logic [19:0] v, input logic [2:0] bits);
        check({12'h000, video}, {12'h000, v});
        check({29'h0, loopback, host_srst, proc_srst}, {29'h0, bits});
    endtask

    task automatic t_reset();
        hr(16'h0100, 32'hC864_0002);
        hr(16'h9204, 32'h0000_1000);
        hr(16'h9210, 32'h0000_01FF);
        for (int i = 1; i < 12; i++) if (i != 8 && i != 10) hr(RW_OFS[i], 32'h0);
        hr(16'h920C, 32'h0);
        outs(20'hC8648, 3'b000);
        check({31'h0, beat.valid}, 32'h0);
        $display("t_reset done");
    endtask

    task automatic t_rw();
        for (int i = 0; i < 12; i++) begin
            hw(RW_OFS[i], 32'hFFFF_FFFF);
            hr(RW_OFS[i], RW_EXP[i]);
        end
        hr(16'h0200, 32'h0);
        hr(16'h0010, 32'h0);
        outs(20'hFFFFF, 3'b110);
        for (int i = 0; i < 12; i++) hw(RW_OFS[i], 32'h0);
        for (int i = 0; i < 12; i++) hr(RW_OFS[i], 32'h0);
        outs(20'h00000, 3'b000);
        $display("t_rw done");
    endtask

    task automatic t_proc();
        bus(1'b1, 1'b1, 16'h0400, 32'h1, 32'h0);
        check({31'h0, proc_srst}, 32'h1);
        bus(1'b1, 1'b1, 16'h0300, 32'h1, 32'h0);
        hr(16'h0300, 32'h0);
        hw(16'h0300, 32'h1);
        bus(1'b1, 1'b0, 16'h0300, 32'h0, 32'h1);
        @(posedge clk_i);
        proc_ready_set <= 1'b1;
        dma_err_set <= 1'b1;
        @(posedge clk_i);
        proc_ready_set <= 1'b0;
        dma_err_set <= 1'b0;
        hw(16'h0404, 32'h0);
        hr(16'h0404, 32'h3);
        bus(1'b1, 1'b1, 16'h0400, 32'h0, 32'h0);
        bus(1'b1, 1'b1, 16'h0104, 32'h1, 32'h0);
        hr(16'h0104, 32'h1);
        hw(16'h0104, 32'h0);
        hw(16'h0300, 32'h0);
        outs(20'h00000, 3'b000);
        $display("t_proc done");
    endtask

    task automatic t_credit();
        @(posedge clk_i);
        credit_valid <= 1'b1;
        credit_value <= 12'hABC;
        @(posedge clk_i);
        credit_value <= 12'h123;
        @(posedge clk_i);
        credit_valid <= 1'b0;
        hr(16'h902C, 32'h0000_0ABC);
        $display("t_credit done");
    endtask

    task automatic t_gen();
        int k;
        k = 0;
        hw(16'h9210, 32'h2);
        hw(16'h9204, 32'h10);
        hw(16'h9200, 32'h1);
        // ready toggles so beats stall every other cycle
        repeat (24) begin
            if (beat.valid === 1'b1 && gen_ready && k < 6) begin
                check(beat.data, (k % 3 == 2) ? 32'h2 : ((k % 3 == 1) ? 32'h1 : 32'h0));
                check({31'h0, beat.last}, {31'h0, k == 3});
                k++;
            end
            @(posedge clk_i);
            gen_ready <= ~gen_ready;
            #1;
        end
        check(k, 6);
        hw(16'h9200, 32'h0);
        @(posedge clk_i);
        #1;
        check({31'h0, beat.valid}, 32'h0);
        // zero length is one beat per packet
        hw(16'h9204, 32'h0);
        hw(16'h9200, 32'h1);
        check({31'h0, beat.last}, 32'h1);
        hw(16'h9200, 32'h0);
        $display("t_gen done");
    endtask

    task automatic send(input logic [31:0] w);
        @(posedge clk_i);
        chk_valid <= 1'b1;
        chk_data <= w;
    endtask
    task automatic t_chk();
        hw(16'h9208, 32'h1);
        send(32'h0);
        send(32'h1);
        send(32'h2);
        send(32'h0);
        @(posedge clk_i);
        chk_valid <= 1'b0;
        chk_data <= 32'hFFFF_FFFF;
        hr(16'h920C, 32'h0);
        send(32'h5);
        @(posedge clk_i);
        chk_valid <= 1'b0;
        hr(16'h920C, 32'h1);
        hw(16'h920C, 32'h0);
        hr(16'h920C, 32'h1);
        hw(16'h920C, 32'h1);
        hr(16'h920C, 32'h0);
        $display("t_chk done");
    endtask

    // reset in mid-run, then every default again
    task automatic t_again();
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // reset for eight cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_rw();
        t_proc();
        t_credit();
        t_gen();
        t_chk();
        t_again();
        results();
    end
endmodule
